// *** stop_event_pkg.sv ***
package stop_event_pkg;

	localparam int ADDR_W = 18;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE   = 16'hf410;
	localparam logic [15:0] IDX_FS0    = 16'hf416;
	localparam logic [15:0] IDX_FS1    = 16'hf418;
	localparam logic [15:0] IDX_ENABLE = 16'hf41a;
	localparam logic [15:0] IDX_STATUS = 16'hf41c;
	localparam logic [15:0] IDX_CLEAR  = 16'hf41e;

	localparam logic [15:0] RST_REG    = 16'h0000;
	localparam logic [15:0] FS_MASK    = 16'h6707;
	localparam logic [15:0] EN_MASK    = 16'h3f7f;
	localparam logic [15:0] OUT1_BITS  = 16'h1818;
	localparam logic [15:0] MODE_MASK  = 16'h0007;

	localparam int FS_QUAL_LSB = 13;
	localparam int FS_SRC_LSB  = 8;
	localparam int FS_HALT     = 2;
	localparam int FS_FRZ1     = 1;
	localparam int FS_FRZ0     = 0;
	localparam int MD_CAPTURE  = 0;
	localparam int MD_LVL0     = 1;
	localparam int MD_LVL1     = 2;
	localparam int EN_TRIG_LSB = 8;

	typedef enum logic [1:0] {
		Q_RISE,
		Q_FALL,
		Q_HIGH,
		Q_LOW
	} qual_t;

	typedef struct packed {
		qual_t      qual;
		logic [2:0] src;
		logic       halt;
		logic       frz1;
		logic       frz0;
	} fs_cfg_t;

	// Period is bit 0, matching status and enable layout
	typedef struct packed {
		logic trig_start;
		logic trig_stop;
		logic fall1;
		logic rise1;
		logic fall0;
		logic rise0;
		logic period;
	} core_ev_t;

endpackage : stop_event_pkg

// *** forced_stop_event_ctrl.sv ***
`timescale 1ns/1ns
module forced_stop_event_ctrl
	import stop_event_pkg::*;
#(
	parameter bit HAS_OUT1 = 1'b1
)
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                sys_rst,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]   avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [3:0]          avs_byteenable,
	input  wire logic [31:0]         avs_writedata,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// Stop sources: ext0, ext2, cmp0..2, ch0..2 out0
	input  wire logic [7:0]          stop_src_pins,
	// Counter core
	input  wire logic                period_end,
	input  wire core_ev_t            core_events,
	input  wire logic [15:0]         counter_value,
	input  wire logic [15:0]         rise0_value,
	input  wire logic                pwm_in_a,
	input  wire logic                pwm_in_b,
	// Results
	output logic                     pwm_output_a,
	output logic                     pwm_output_b,
	output logic                     counter_halt,
	output logic                     forced_stop_active,
	output logic                     channel_irq_out,
	output logic                     channel_trigger_out
);

	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [7:0] src_meta_q;
	logic [7:0] src_sync_q;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_sync
			always_ff @(posedge clock or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					src_meta_q[gi] <= 1'b0;
					src_sync_q[gi] <= 1'b0;
				end
				else
				begin
					src_meta_q[gi] <= stop_src_pins[gi];
					src_sync_q[gi] <= src_meta_q[gi];
				end
			end
		end
	endgenerate

	// ************************************************
	// Register bus
	// ************************************************
	logic [15:0] mode_q, mode_d;
	logic [15:0] fs0_q, fs0_d;
	logic [15:0] fs1_q, fs1_d;
	logic [15:0] en_q, en_d;
	logic [7:0]  st_q, st_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        req;
	logic        wr_go;
	logic [15:0] widx;
	logic [15:0] rd_val;
	logic [15:0] out1_keep;
	logic [7:0]  st_set;
	logic [7:0]  st_clr;

	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign widx            = avs_address[ADDR_W-1:2];
	assign wr_go           = avs_write & ack_q;
	assign out1_keep       = HAS_OUT1 ? 16'hffff : ~OUT1_BITS;

	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be,
		input logic [15:0] mask
	);
		logic [15:0] v;
		v = old;
		if (be[0])
			v[7:0] = wd[7:0];
		if (be[1])
			v[15:8] = wd[15:8];
		return v & mask;
	endfunction : merge16

	always_comb
	begin
		rd_val = 16'h0000;
		case (widx)
			IDX_MODE:   rd_val = mode_q;
			IDX_FS0:    rd_val = fs0_q;
			IDX_FS1:    rd_val = fs1_q;
			IDX_ENABLE: rd_val = en_q;
			IDX_STATUS: rd_val = {8'h00, st_q};
			default:    rd_val = 16'h0000;
		endcase
	end

	always_comb
	begin
		ack_d   = req & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read & ~ack_q)
			rdata_d = {16'h0000, rd_val};
		mode_d = mode_q;
		fs0_d  = fs0_q;
		fs1_d  = fs1_q;
		en_d   = en_q;
		st_clr = 8'h00;
		if (wr_go)
		begin
			case (widx)
				IDX_MODE:
					mode_d = merge16(mode_q, avs_writedata,
						avs_byteenable, MODE_MASK);
				IDX_FS0:
					fs0_d = merge16(fs0_q, avs_writedata,
						avs_byteenable, FS_MASK & out1_keep);
				IDX_FS1:
					fs1_d = merge16(fs1_q, avs_writedata,
						avs_byteenable, FS_MASK & out1_keep);
				IDX_ENABLE:
					en_d = merge16(en_q, avs_writedata,
						avs_byteenable, EN_MASK & out1_keep);
				IDX_CLEAR:
					if (avs_byteenable[0])
						st_clr = avs_writedata[7:0];
				default:
					st_clr = 8'h00;
			endcase
		end
		// Set beats a same-cycle clear
		st_d = (st_q & ~st_clr) | st_set;
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
			mode_q  <= RST_REG;
			fs0_q   <= RST_REG;
			fs1_q   <= RST_REG;
			en_q    <= RST_REG;
			st_q    <= 8'h00;
		end
		else
		begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			mode_q  <= mode_d;
			fs0_q   <= fs0_d;
			fs1_q   <= fs1_d;
			en_q    <= en_d;
			st_q    <= st_d;
		end
	end

	// ************************************************
	// Forced-stop paths
	// ************************************************
	fs_cfg_t    cfg [2];
	logic [1:0] prev_q, prev_d;
	logic [1:0] act_q, act_d;
	logic [1:0] disarm;
	logic [1:0] sel;

	assign cfg[0] = '{qual: qual_t'(fs0_q[FS_QUAL_LSB +: 2]),
		src: fs0_q[FS_SRC_LSB +: 3], halt: fs0_q[FS_HALT],
		frz1: fs0_q[FS_FRZ1], frz0: fs0_q[FS_FRZ0]};
	assign cfg[1] = '{qual: qual_t'(fs1_q[FS_QUAL_LSB +: 2]),
		src: fs1_q[FS_SRC_LSB +: 3], halt: fs1_q[FS_HALT],
		frz1: fs1_q[FS_FRZ1], frz0: fs1_q[FS_FRZ0]};

	// Writing a path with halt and freezes off drops a stuck stop
	assign disarm[0] = wr_go & (widx == IDX_FS0) &
		~|(fs0_d & 16'h0007);
	assign disarm[1] = wr_go & (widx == IDX_FS1) &
		~|(fs1_d & 16'h0007);

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_path
			always_comb
			begin
				sel[gi]    = src_sync_q[cfg[gi].src];
				prev_d[gi] = sel[gi];
				act_d[gi]  = act_q[gi];
				case (cfg[gi].qual)
					Q_RISE:
						act_d[gi] = (sel[gi] & ~prev_q[gi]) |
							(act_q[gi] & ~disarm[gi] &
							~(period_end & ~cfg[gi].halt));
					Q_FALL:
						act_d[gi] = (~sel[gi] & prev_q[gi]) |
							(act_q[gi] & ~disarm[gi] &
							~(period_end & ~cfg[gi].halt));
					Q_HIGH:
						act_d[gi] = sel[gi];
					Q_LOW:
						act_d[gi] = ~sel[gi];
					default:
						act_d[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_q <= 2'b00;
			act_q  <= 2'b00;
		end
		else
		begin
			prev_q <= prev_d;
			act_q  <= act_d;
		end
	end

	// ************************************************
	// Outputs and events
	// ************************************************
	logic     frz_a, frz_b, halt_d, fs_d;
	logic     out_a_d, out_b_d, out_a_q, out_b_q;
	logic     halt_q, fs_q, irq_q, irq_d, trg_q, trg_d;
	logic     half_q, half_match;
	logic     capture;
	core_ev_t ev;
	logic [5:0] trg_ev;

	assign capture    = mode_q[MD_CAPTURE];
	assign half_match = counter_value == (rise0_value >> 1);

	always_comb
	begin
		fs_d   = |act_q;
		halt_d = (act_q[0] & cfg[0].halt) |
			(act_q[1] & cfg[1].halt);
		frz_a  = (act_q[0] & cfg[0].frz0) |
			(act_q[1] & cfg[1].frz0);
		frz_b  = HAS_OUT1 & ((act_q[0] & cfg[0].frz1) |
			(act_q[1] & cfg[1].frz1));
		out_a_d = frz_a ? mode_q[MD_LVL0] : pwm_in_a;
		out_b_d = frz_b ? mode_q[MD_LVL1] : pwm_in_b;
		// Output 1 matches do not exist in capture mode
		ev        = core_events;
		ev.rise1  = core_events.rise1 & ~capture & HAS_OUT1;
		ev.fall1  = core_events.fall1 & ~capture & HAS_OUT1;
		st_set    = {|(act_q & ~{fs_q, fs_q}) & ~fs_q, ev};
		irq_d     = |(ev & en_q[6:0]);
		trg_ev    = {half_match & ~half_q, ev.fall1, ev.rise1,
			ev.fall0, ev.rise0, ev.period};
		trg_d     = |(trg_ev & en_q[EN_TRIG_LSB +: 6]);
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
			halt_q  <= 1'b0;
			fs_q    <= 1'b0;
			irq_q   <= 1'b0;
			trg_q   <= 1'b0;
			half_q  <= 1'b0;
		end
		else
		begin
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
			halt_q  <= halt_d;
			fs_q    <= fs_d;
			irq_q   <= irq_d;
			trg_q   <= trg_d;
			half_q  <= half_match;
		end
	end

	assign pwm_output_a        = out_a_q;
	assign pwm_output_b        = out_b_q;
	assign counter_halt        = halt_q;
	assign forced_stop_active  = fs_q;
	assign channel_irq_out     = irq_q;
	assign channel_trigger_out = trg_q;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_stop_or_merge: assert property (act_q != 2'b00 |=> fs_q)
		else $error("forced stop not reported");
	a_halt_path0: assert property (act_q[0] && cfg[0].halt
		|=> counter_halt)
		else $error("counter not halted by path 0");
	a_halt_keep: assert property (act_q == 2'b00 |=> !counter_halt)
		else $error("counter halted without stop");
	a_freeze_out0: assert property (act_q[1] && cfg[1].frz0
		|=> pwm_output_a == $past(mode_q[MD_LVL0]))
		else $error("output 0 not frozen");
	a_level_hold: assert property (cfg[0].qual == Q_HIGH
		&& src_sync_q[cfg[0].src] |=> act_q[0])
		else $error("level stop released");
	a_period_irq: assert property (core_events.period && en_q[0]
		|=> channel_irq_out && st_q[0])
		else $error("period interrupt missing");
	a_capture_mask: assert property (capture && !core_events.period
		&& !core_events.rise0 && !core_events.fall0 && en_q[15:8] == 8'h18
		|=> !channel_trigger_out)
		else $error("output 1 trigger in capture mode");
	a_status_set: assert property (core_events.rise0 |=> st_q[1])
		else $error("status set lost");
	a_bus_answer: assert property (req && !ack_q
		|=> !avs_waitrequest || !req)
		else $error("bus answer late");

	c_edge_stop:  cover property (act_q[0] ##[1:20] !act_q[0]);
	c_trig_out:   cover property (channel_trigger_out);
	c_clear_race: cover property (st_clr[0] && st_set[0]);

endmodule : forced_stop_event_ctrl

// *** core_model.sv ***
`timescale 1ns/1ns
module core_model
	import stop_event_pkg::*;
#(
	parameter int PERIOD = 16
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// From block and bench
	input  wire logic        halt,
	input  wire core_ev_t    ev_req,
	// To block
	output logic             period_end,
	output core_ev_t         core_events,
	output logic      [15:0] counter_value,
	output logic             pwm_in_a,
	output logic             pwm_in_b
);
	// ********
	// Counter
	// ********
	// Count freezes while halted, so a halt shows on the count
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			counter_value <= 16'h0000;
		else if (!halt)
			counter_value <= period_end ? 16'h0000 : counter_value + 16'h0001;
	assign period_end = !halt && counter_value == 16'(PERIOD - 1);
	assign core_events = ev_req;
	assign pwm_in_a = counter_value < 16'(PERIOD / 2);
	assign pwm_in_b = counter_value[1];
endmodule : core_model

// *** tb_timer_forced_stop_and_event_enable.sv ***
`timescale 1ns/1ns
module tb_timer_forced_stop_and_event_enable
	import stop_event_pkg::*;
#(
	parameter int PERIOD = 16
);
	logic              clock = 1'b0;
	logic              sys_rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = '0;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic [7:0]        pins = '0;
	core_ev_t          ev_req = '0;
	core_ev_t          core_events;
	logic [15:0]       counter_value;
	logic [15:0]       rise0 = '0;
	logic              period_end, pwm_a, pwm_b, out_a, out_b;
	logic              counter_halt, fs_act, irq, trig;
	int                num_errors = 0;
	int                samples_checked = 0;
	integer            seed = 94;
	logic [15:0]       ridx [4] = '{IDX_FS0, IDX_FS1, IDX_ENABLE, IDX_MODE};
	logic [15:0]       rmsk [4] = '{FS_MASK, FS_MASK, EN_MASK, MODE_MASK};

	always #5 clock = ~clock;

	forced_stop_event_ctrl u_dut (
		.clock(clock), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'h3),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stop_src_pins(pins),
		.period_end(period_end), .core_events(core_events),
		.counter_value(counter_value), .rise0_value(rise0),
		.pwm_in_a(pwm_a), .pwm_in_b(pwm_b),
		.pwm_output_a(out_a), .pwm_output_b(out_b),
		.counter_halt(counter_halt), .forced_stop_active(fs_act),
		.channel_irq_out(irq), .channel_trigger_out(trig)
	);

	core_model #(.PERIOD(PERIOD)) u_core (
		.clock(clock), .sys_rst(sys_rst), .halt(counter_halt),
		.ev_req(ev_req), .period_end(period_end),
		.core_events(core_events), .counter_value(counter_value),
		.pwm_in_a(pwm_a), .pwm_in_b(pwm_b)
	);

	// ********
	// Tasks
	// ********
	task automatic complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Starts after an edge, holds until waitrequest low at an edge
	task automatic bus(input logic wr, input logic [15:0] idx, wd,
		output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {16'h0000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			num_errors++;
	endtask : bus

	task automatic wr(input logic [15:0] idx, wd);
		logic [15:0] x;
		bus(1'b1, idx, wd, x);
	endtask : wr

	task automatic rdchk(input string nm, input logic [15:0] idx, e);
		logic [15:0] x;
		bus(1'b0, idx, 16'h0000, x);
		chk(nm, e, x);
	endtask : rdchk

	task automatic wait_fs(input logic val, input int lim);
		int n;
		n = 0;
		while (fs_act !== val && n < lim)
		begin
			@(negedge clock);
			n++;
		end
		chk("fs_act", {15'h0, val}, {15'h0, fs_act});
	endtask : wait_fs

	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		complete_run();
	end

	// ********
	// Sequence
	// ********
	initial
	begin : main
		logic [15:0] v, en, c;
		logic [2:0] s;
		logic [1:0] lv;
		logic cap, e1, idle;
		int k, i, j;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		rdchk("fs0", IDX_FS0, RST_REG);
		rdchk("fs1", IDX_FS1, RST_REG);
		rdchk("en", IDX_ENABLE, RST_REG);
		wr(IDX_STATUS, 16'hffff);
		rdchk("stat", IDX_STATUS, RST_REG);
		wr(16'hf414, 16'hffff);
		rdchk("hole", 16'hf414, RST_REG);
		for (k = 0; k < 24; k++)
		begin
			s = 3'($random(seed));
			v = 16'($random(seed));
			wr(ridx[s[1:0]], v);
			rdchk("reg", ridx[s[1:0]], v & rmsk[s[1:0]]);
		end
		for (k = 0; k < 4; k++)
			wr(ridx[k], 16'h0000);
		repeat (3 * PERIOD) @(posedge clock);
		// Capture mode in the last third of the loop
		for (k = 0; k < 21; k++)
		begin
			i = k % 7;
			en = 16'($random(seed)) & 16'h1f7f;
			cap = k >= 14;
			e1 = !(cap && (i == 3 || i == 4));
			wr(IDX_ENABLE, en);
			wr(IDX_MODE, {15'h0, cap});
			wr(IDX_CLEAR, 16'h00ff);
			@(posedge clock);
			ev_req <= core_ev_t'(7'(1) << i);
			@(posedge clock);
			ev_req <= '0;
			@(negedge clock);
			chk("irq", {15'h0, en[i] & e1}, {15'h0, irq});
			chk("trig", {15'h0, i < 5 && en[8+i] && e1}, {15'h0, trig});
			rdchk("stat", IDX_STATUS, 16'(e1) << i);
			wr(IDX_CLEAR, 16'(1) << i);
			rdchk("clr", IDX_STATUS, RST_REG);
		end
		wr(IDX_MODE, 16'h0000);
		wr(IDX_ENABLE, 16'h2000);
		for (k = 0; k < 4; k++)
		begin
			@(posedge clock);
			rise0 <= 16'(2 + $unsigned($random(seed)) % (2 * PERIOD - 4));
			j = 0;
			do
			begin
				c = counter_value;
				@(negedge clock);
				j++;
			end
			while (trig !== 1'b1 && j < 4 * PERIOD);
			chk("half", rise0 >> 1, c);
		end
		wr(IDX_ENABLE, 16'h0000);
		// Rise, fall, high, low; paths alternate, level cases halt
		for (k = 0; k < 4; k++)
		begin
			s = 3'($random(seed));
			lv = 2'($random(seed));
			idle = k[0];
			pins <= {8{idle}};
			wr(IDX_MODE, {13'h0, lv, 1'b0});
			v = {1'b0, 2'(k), 2'b00, s, 5'h00, k[1], 2'b11};
			wr(k[0] ? IDX_FS1 : IDX_FS0, v);
			@(negedge clock);
			while (counter_value !== 16'h0002)
				@(negedge clock);
			@(posedge clock);
			pins[s] <= !idle;
			repeat (3) @(posedge clock);
			pins[s] <= k[1] ? !idle : idle;
			repeat (7) @(posedge clock);
			@(negedge clock);
			chk("stop", 16'h0001, {15'h0, fs_act});
			chk("out0", {15'h0, lv[0]}, {15'h0, out_a});
			chk("out1", {15'h0, lv[1]}, {15'h0, out_b});
			chk("halt", {15'h0, k[1]}, {15'h0, counter_halt});
			if (k[1])
			begin
				c = counter_value;
				repeat (3 * PERIOD) @(negedge clock);
				chk("count", c, counter_value);
				chk("lvl", 16'h0001, {15'h0, fs_act});
				@(posedge clock);
				pins[s] <= idle;
				wr(k[0] ? IDX_FS1 : IDX_FS0, 16'h0000);
			end
			wait_fs(1'b0, PERIOD + 8);
			wr(k[0] ? IDX_FS1 : IDX_FS0, 16'h0000);
		end
		complete_run();
	end
endmodule : tb_timer_forced_stop_and_event_enable
